// file: rtl/pplps_act_stretch.v
// Activity stretcher holding the activity indication for a number of update periods
`timescale 1ns/10ps
`include "pplps_defines.vh"
module pplps_act_stretch #(
  parameter PERIOD_CYC = 32'd2000000
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire pulse,
  output reg active
);
  localparam integer PERIODS_I = `PPLPS_ACT_PERIODS;
  localparam [2:0] PERIODS = PERIODS_I[2:0];
  reg [31:0] tick_cnt;
  reg [2:0] periods_left;
  wire tick = (tick_cnt == PERIOD_CYC - 32'd1);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0000_0000;
      periods_left <= 3'h0;
      active <= 1'b0;
    end else if (ce) begin
      if (pulse) begin
        tick_cnt <= 32'h0000_0000;
        periods_left <= PERIODS; // RULE_15
        active <= 1'b1;
      end else if (active) begin
        if (tick) begin
          tick_cnt <= 32'h0000_0000;
          if (periods_left == 3'h1) begin
            active <= 1'b0;
          end
          periods_left <= periods_left - 3'h1;
        end else begin
          tick_cnt <= tick_cnt + 32'h0000_0001;
        end
      end
    end
  end
endmodule

// file: rtl/pplps_defines.vh
// Register offsets, field positions, reset values and timing counts of the port link block
`ifndef PPLPS_DEFINES_VH
`define PPLPS_DEFINES_VH
// APB register byte offsets
`define PPLPS_OFF_LINK_CTRL 12'h000
`define PPLPS_OFF_LINK_CTRL2 12'h004
`define PPLPS_OFF_REJ_TIMER 12'h008
`define PPLPS_OFF_PHY_CFG0 12'h00c
`define PPLPS_OFF_PRBS_SEED 12'h010
`define PPLPS_OFF_PORT_STS 12'h014
// Field positions
`define PPLPS_LC_ASPM_L1 1
`define PPLPS_LC2_DEEMPH 6
`define PPLPS_RT_START_SEL 16
`define PPLPS_CFG0_XLDIS 0
`define PPLPS_CFG0_SPDCHG 1
`define PPLPS_STS_LANEMODE 0
`define PPLPS_STS_LINKUP 1
`define PPLPS_STS_GAP_BUSY 2
`define PPLPS_STS_SPEED 3
`define PPLPS_STS_DEEMPH 4
`define PPLPS_STS_XLINK 5
// Reset values
`define PPLPS_RST_LINK_CTRL 32'h0000_0000
`define PPLPS_RST_LINK_CTRL2 32'h0000_0000
`define PPLPS_RST_PHY_CFG0 32'h0000_0000
`define PPLPS_RST_PRBS_SEED 32'h0000_0000
// Minimum gap timer, in units of 100 ns (5 clocks at 20 ns)
`define PPLPS_CLK_NS 20
`define PPLPS_GAP_UNIT_NS 100
`define PPLPS_GAP_UNIT_CYC (`PPLPS_GAP_UNIT_NS / `PPLPS_CLK_NS)
`define PPLPS_GAP_MIN_UNITS 16'h0001
`define PPLPS_GAP_MAX_UNITS 16'h0280
`define PPLPS_GAP_RST_UNITS 16'h005f
// Activity stretch: 200 ms as five 40 ms update periods
`define PPLPS_ACT_MS 200
`define PPLPS_ACT_PERIOD_MS 40
`define PPLPS_ACT_PERIODS (`PPLPS_ACT_MS / `PPLPS_ACT_PERIOD_MS)
`define PPLPS_ACT_PERIOD_CYC (`PPLPS_ACT_PERIOD_MS * 1000000 / `PPLPS_CLK_NS)
// LTSSM state codes seen from the PHY
`define PPLPS_LT_L0 4'h3
`define PPLPS_LT_L0S 4'h4
`define PPLPS_LT_L1 4'h5
`define PPLPS_LT_RECOV 4'h6
`define PPLPS_LT_POLL_COMPL 4'h2
`endif

// file: rtl/pplps_port_link.v
// Per-port link power, status, de-emphasis and crosslink control with APB registers
`timescale 1ns/10ps
`include "pplps_defines.vh"
// Document rules for this block and its link partner
// RULE_01: Answer L1 requests only when ASPM L1 enabled
// RULE_02: Accept only with no TLP/ACK/NAK pending
// RULE_03: Partner repeats L1 requests until answered
// RULE_04: On accept, repeat request ack until idle
// RULE_05: On reject, send exactly one nak TLP
// RULE_06: Partner enters then leaves L0s before retrying
// RULE_07: Partner staying in L0 waits 10 us
// RULE_08: Per-port gap timer from its control register
// RULE_09: Gap programmable 100 ns-64 us, resets 9.5 us
// RULE_10: Requests inside gap get no answer
// RULE_11: Default timer starts at nak send
// RULE_12: Start-select waits for idle receive lanes
// RULE_13: Link-up low while data link up
// RULE_14: Activity low on any non-vendor TLP
// RULE_15: Activity held at least 200 ms
// RULE_16: Gen1 -3.5dB; Gen2 uses select field
// RULE_17: De-emphasis negotiated in Recovery via training sets
// RULE_18: Upstream port advertises field, adopts partner choice
// RULE_19: Downstream port ignores partner, uses own field
// RULE_20: Training picks lane role; status reports it
// RULE_21: Same-group crosslink needs different PRBS seeds
// RULE_22: Up-up crosslink stays Gen1 unless speed-change set
// RULE_23: Crosslink enabled at reset, disable bit clears
module pplps_port_link #(
  parameter ACT_PERIOD_CYC = 32'd2000000
) (
  input wire mclk,
  input wire rstn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire port_is_downstream,
  input wire [3:0] ltssm_state,
  input wire rx_l1_request,
  input wire tlp_pending,
  input wire acknak_pending,
  input wire rx_lanes_active,
  input wire tlp_tx,
  input wire tlp_rx,
  input wire tlp_is_vendor_msg,
  input wire partner_deemph_req,
  input wire at_gen2,
  input wire train_lanes_downstream,
  input wire crosslink_formed,
  input wire partner_is_upstream,
  input wire nak_sent,
  output reg tx_l1_ack,
  output reg tx_aspm_nak,
  output reg tx_deemph_adv,
  output reg deemph_6db,
  output reg speed_change_req,
  output reg crosslink_enable,
  output reg [31:0] phy_prbs_seed_reg,
  output reg port_link_up_n,
  output reg port_activity_n
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ACK = 2'h1;
  localparam ST_NAK_WAIT = 2'h2;
  localparam ST_GAP = 2'h3;

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  reg rst_meta;
  reg rst_n;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [15:0] clamp_gap;
    input [15:0] v;
    begin
      if (v < `PPLPS_GAP_MIN_UNITS) begin
        clamp_gap = `PPLPS_GAP_MIN_UNITS;
      end else if (v > `PPLPS_GAP_MAX_UNITS) begin
        clamp_gap = `PPLPS_GAP_MAX_UNITS;
      end else begin
        clamp_gap = v;
      end
    end
  endfunction

  function link_is_up;
    input [3:0] s;
    begin
      link_is_up = (s == `PPLPS_LT_L0) || (s == `PPLPS_LT_L0S) || (s == `PPLPS_LT_L1) || (s == `PPLPS_LT_RECOV);
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] link_control_reg;
  reg [31:0] link_control2_reg;
  reg [15:0] min_l1_request_gap;
  reg timer_start_select;
  reg [31:0] phy_link_config0;
  reg [1:0] state;
  reg [15:0] gap_units;
  reg [2:0] unit_cyc;
  reg gap_running;
  reg lane_direction_mode;
  reg gen2_now;

  wire [31:0] l1_reject_timer_ctrl = {15'h0000, timer_start_select, min_l1_request_gap};
  wire [31:0] switch_port_status = {26'h0000000, crosslink_enable, deemph_6db, gen2_now, (state == ST_GAP),
    ~port_link_up_n, lane_direction_mode};
  wire crosslink_disable = phy_link_config0[`PPLPS_CFG0_XLDIS];
  wire crosslink_speed_change_init = phy_link_config0[`PPLPS_CFG0_SPDCHG];
  wire deemphasis_select = link_control2_reg[`PPLPS_LC2_DEEMPH];
  wire l1_enabled = link_control_reg[`PPLPS_LC_ASPM_L1];
  wire wr_en = psel && penable && pwrite && !pready;
  wire rd_en = psel && penable && !pwrite && !pready;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link_control_reg <= `PPLPS_RST_LINK_CTRL;
      link_control2_reg <= `PPLPS_RST_LINK_CTRL2;
      min_l1_request_gap <= `PPLPS_GAP_RST_UNITS; // RULE_09
      timer_start_select <= 1'b0;
      phy_link_config0 <= `PPLPS_RST_PHY_CFG0;
      phy_prbs_seed_reg <= `PPLPS_RST_PRBS_SEED;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (wr_en) begin
        if (paddr == `PPLPS_OFF_LINK_CTRL) begin
          link_control_reg <= pwdata;
        end else if (paddr == `PPLPS_OFF_LINK_CTRL2) begin
          link_control2_reg <= pwdata;
        end else if (paddr == `PPLPS_OFF_REJ_TIMER) begin
          min_l1_request_gap <= clamp_gap(pwdata[15:0]); // RULE_09
          timer_start_select <= pwdata[`PPLPS_RT_START_SEL];
        end else if (paddr == `PPLPS_OFF_PHY_CFG0) begin
          phy_link_config0 <= pwdata;
        end else if (paddr == `PPLPS_OFF_PRBS_SEED) begin
          phy_prbs_seed_reg <= pwdata;
        end else if (paddr != `PPLPS_OFF_PORT_STS) begin
          pslverr <= 1'b1;
        end
      end
      if (rd_en) begin
        if (paddr == `PPLPS_OFF_LINK_CTRL) begin
          prdata <= link_control_reg;
        end else if (paddr == `PPLPS_OFF_LINK_CTRL2) begin
          prdata <= link_control2_reg;
        end else if (paddr == `PPLPS_OFF_REJ_TIMER) begin
          prdata <= l1_reject_timer_ctrl;
        end else if (paddr == `PPLPS_OFF_PHY_CFG0) begin
          prdata <= phy_link_config0;
        end else if (paddr == `PPLPS_OFF_PRBS_SEED) begin
          prdata <= phy_prbs_seed_reg;
        end else if (paddr == `PPLPS_OFF_PORT_STS) begin
          prdata <= switch_port_status;
        end else begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // L1 entry handshake and minimum gap timer
  // ----------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      tx_l1_ack <= 1'b0;
      tx_aspm_nak <= 1'b0;
      gap_units <= 16'h0000;
      unit_cyc <= 3'h0;
      gap_running <= 1'b0;
    end else if (ce) begin
      tx_aspm_nak <= 1'b0;
      case (state)
        ST_IDLE: begin
          tx_l1_ack <= 1'b0;
          if (port_is_downstream && l1_enabled && rx_l1_request) begin // RULE_01
            if (!tlp_pending && !acknak_pending) begin // RULE_02
              state <= ST_ACK;
              tx_l1_ack <= 1'b1; // RULE_04
            end else begin
              state <= ST_NAK_WAIT;
              tx_aspm_nak <= 1'b1; // RULE_05
            end
          end
        end
        ST_ACK: begin
          if (ltssm_state == `PPLPS_LT_L1 || !link_is_up(ltssm_state)) begin // RULE_04
            tx_l1_ack <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_NAK_WAIT: begin
          if (nak_sent) begin
            state <= ST_GAP;
            gap_units <= 16'h0000;
            unit_cyc <= 3'h0;
            gap_running <= !timer_start_select; // RULE_11
          end
        end
        ST_GAP: begin
          if (!gap_running) begin
            if (!rx_lanes_active) begin
              gap_running <= 1'b1; // RULE_12
            end
          end else if (unit_cyc == `PPLPS_GAP_UNIT_CYC - 1) begin
            unit_cyc <= 3'h0;
            if (gap_units + 16'h0001 >= min_l1_request_gap) begin // RULE_08
              state <= ST_IDLE;
              gap_running <= 1'b0;
            end
            gap_units <= gap_units + 16'h0001;
          end else begin
            unit_cyc <= unit_cyc + 3'h1;
          end
          // Requests seen here are ignored // RULE_10
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Link status outputs
  // ----------------------------------------
  wire act_level;
  pplps_act_stretch #(
    .PERIOD_CYC(ACT_PERIOD_CYC)
  ) u_act (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .pulse((tlp_tx || tlp_rx) && !tlp_is_vendor_msg), // RULE_14
    .active(act_level)
  );

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_link_up_n <= 1'b1;
      port_activity_n <= 1'b1;
    end else if (ce) begin
      port_link_up_n <= !link_is_up(ltssm_state); // RULE_13
      port_activity_n <= !act_level; // RULE_15
    end
  end

  // ----------------------------------------
  // De-emphasis and crosslink
  // ----------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_deemph_adv <= 1'b0;
      deemph_6db <= 1'b0;
      speed_change_req <= 1'b0;
      crosslink_enable <= 1'b1;
      lane_direction_mode <= 1'b0;
      gen2_now <= 1'b0;
    end else if (ce) begin
      gen2_now <= at_gen2;
      crosslink_enable <= !crosslink_disable; // RULE_23
      tx_deemph_adv <= deemphasis_select; // RULE_18
      if (!at_gen2) begin
        deemph_6db <= 1'b0; // RULE_16
      end else if (ltssm_state == `PPLPS_LT_RECOV || ltssm_state == `PPLPS_LT_POLL_COMPL) begin // RULE_17
        if (port_is_downstream) begin
          deemph_6db <= deemphasis_select; // RULE_19
        end else begin
          deemph_6db <= partner_deemph_req; // RULE_18
        end
      end
      if (crosslink_formed && !crosslink_disable) begin
        lane_direction_mode <= train_lanes_downstream; // RULE_20
      end else begin
        lane_direction_mode <= port_is_downstream;
      end
      speed_change_req <= !port_is_downstream && crosslink_formed && partner_is_upstream &&
        crosslink_speed_change_init && !at_gen2; // RULE_22
    end
  end
endmodule

// file: verification/pplps_chk_sva.sv
// Assertion checker for the port link block
`timescale 1ns/10ps
module pplps_chk_sva #(
  parameter ACT_PERIOD_CYC = 32'd2000000
) (
  input wire mclk,
  input wire rstn,
  input wire [3:0] ltssm_state,
  input wire rx_l1_request,
  input wire port_is_downstream,
  input wire tlp_pending,
  input wire acknak_pending,
  input wire tlp_tx,
  input wire tlp_rx,
  input wire tlp_is_vendor_msg,
  input wire at_gen2,
  input wire crosslink_formed,
  input wire partner_is_upstream,
  input wire tx_l1_ack,
  input wire tx_aspm_nak,
  input wire deemph_6db,
  input wire speed_change_req,
  input wire crosslink_enable,
  input wire port_link_up_n,
  input wire port_activity_n
);
  // ----
  // Cycle counters
  // ----
  reg [2:0] rc;
  reg [31:0] ac;
  wire ok = rc == 3'h7;
  wire up = ltssm_state >= 4'h3 && ltssm_state <= 4'h6;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rc <= 3'h0;
      ac <= 32'h0;
    end else begin
      rc <= ok ? rc : rc + 3'h1;
      ac <= port_activity_n ? 32'h0 : ac + 32'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_reset_outputs: assert property (rc == 3'h1 |-> crosslink_enable && port_link_up_n)
    else $error("reset output levels wrong");
  a_link_up: assert property (ok |=> port_link_up_n != $past(up))
    else $error("link up status wrong");
  a_nak_single: assert property (tx_aspm_nak |=> !tx_aspm_nak [*4])
    else $error("nak repeated");
  a_answer_cause: assert property ($rose(tx_l1_ack) || tx_aspm_nak |-> $past(rx_l1_request && port_is_downstream))
    else $error("answer without request");
  a_accept_idle: assert property ($rose(tx_l1_ack) |-> $past(!tlp_pending && !acknak_pending))
    else $error("accept while busy");
  a_reject_busy: assert property (tx_aspm_nak |-> $past(tlp_pending || acknak_pending))
    else $error("reject while idle");
  a_ack_held: assert property (tx_l1_ack && ltssm_state == 4'h3 |=> tx_l1_ack)
    else $error("ack dropped early");
  a_gen1_deemph: assert property (ok && !at_gen2 ##1 !at_gen2 |-> !deemph_6db)
    else $error("gen1 de-emphasis wrong");
  a_act_start: assert property (ok && (tlp_tx || tlp_rx) && !tlp_is_vendor_msg |-> ##2 !port_activity_n)
    else $error("activity not shown");
  a_act_stretch: assert property (ok && $rose(port_activity_n) |-> ac >= 5 * ACT_PERIOD_CYC)
    else $error("activity too short");
  a_speed_cause: assert property (speed_change_req |-> $past(crosslink_formed && partner_is_upstream
    && !port_is_downstream && !at_gen2))
    else $error("speed change without cause");
endmodule

// file: verification/pplps_partner.sv
// Link partner model making L1 entry requests
`timescale 1ns/10ps
module pplps_partner (
  input wire mclk,
  input wire go,
  input wire [7:0] gap,
  input wire [3:0] lt_cmd,
  input wire tx_l1_ack,
  input wire tx_aspm_nak,
  output reg rx_l1_request,
  output reg nak_sent,
  output reg [3:0] ltssm_state
);
  reg [7:0] w = 8'h00;
  initial begin
    rx_l1_request = 1'b0;
    nak_sent = 1'b0;
    ltssm_state = 4'h0;
  end
  always @(posedge mclk) begin
    nak_sent <= tx_aspm_nak;
    ltssm_state <= tx_l1_ack ? 4'h5 : lt_cmd;
    if (tx_l1_ack || tx_aspm_nak) begin
      rx_l1_request <= 1'b0;
      w <= gap;
    end else if (w != 8'h00) begin
      w <= w - 8'h01;
    end else begin
      rx_l1_request <= go;
    end
  end
endmodule

// file: verification/pplps_tb.sv
// Self-checking bench for the port link block
`timescale 1ns/10ps
module testbench;
  reg mclk, rstn, psel, penable, pwrite, go, er;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [31:0] seed = 32'h0000f944;
  reg port_is_downstream, tlp_pending, acknak_pending, rx_lanes_active, tlp_tx, tlp_rx, tlp_is_vendor_msg;
  reg partner_deemph_req, at_gen2, train_lanes_downstream, crosslink_formed, partner_is_upstream;
  reg [3:0] lt_cmd;
  wire [31:0] prdata, phy_prbs_seed_reg;
  wire [3:0] ltssm_state;
  wire pready, pslverr, tx_l1_ack, tx_aspm_nak, tx_deemph_adv, deemph_6db, speed_change_req;
  wire crosslink_enable, port_link_up_n, port_activity_n, rx_l1_request, nak_sent;
  int mismatches, checks, n, u, v, sel;
  pplps_port_link #(.ACT_PERIOD_CYC(32'h0000000a)) pplps_port_link_inst (
    .mclk, .rstn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .port_is_downstream, .ltssm_state, .rx_l1_request, .tlp_pending, .acknak_pending, .rx_lanes_active,
    .tlp_tx, .tlp_rx, .tlp_is_vendor_msg, .partner_deemph_req, .at_gen2, .train_lanes_downstream,
    .crosslink_formed, .partner_is_upstream, .nak_sent, .tx_l1_ack, .tx_aspm_nak, .tx_deemph_adv,
    .deemph_6db, .speed_change_req, .crosslink_enable, .phy_prbs_seed_reg, .port_link_up_n, .port_activity_n);
  pplps_partner pplps_partner_inst (.mclk, .go, .gap(8'h02), .lt_cmd, .tx_l1_ack, .tx_aspm_nak,
    .rx_l1_request, .nak_sent, .ltssm_state);
  // ----
  // Helpers
  // ----
  function automatic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic [31:0] clamp(input [31:0] x);
    return x < 1 ? 1 : (x > 640 ? 640 : x);
  endfunction
  task automatic chk(input [31:0] got, input [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input bit w, input [11:0] a, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic ans(int m);
    n = 0;
    while (tx_l1_ack !== 1'b1 && tx_aspm_nak !== 1'b1 && n < m) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, go, lt_cmd, rstn} = '0;
    {port_is_downstream, tlp_pending, acknak_pending, rx_lanes_active, tlp_tx, tlp_rx} = '0;
    {tlp_is_vendor_msg, partner_deemph_req, at_gen2, train_lanes_downstream, crosslink_formed} = '0;
    partner_is_upstream = 1'b0;
    repeat (8) @(posedge mclk);
    chk({crosslink_enable, port_link_up_n, port_activity_n}, 3'h7);
    rstn <= 1'b1;
    lt_cmd <= 4'h3;
    repeat (3) @(posedge mclk);
    apb(0, 12'h008, 0);
    chk(rd, 32'h0000005f);
    apb(0, 12'h020, 0);
    chk(er, 1);
    chk(rd, 0);
    for (int i = 0; i < 4; i++) begin
      v = i ? rnd() % 1024 : 0;
      apb(1, 12'h008, v);
      apb(0, 12'h008, 0);
      chk(rd, clamp(v));
    end
    v = rnd();
    apb(1, 12'h010, v);
    chk(phy_prbs_seed_reg, v);
    port_is_downstream <= 1'b1;
    go <= 1'b1;
    ans(20);
    chk(n, 20);
    apb(1, 12'h000, 32'h00000002);
    ans(20);
    chk(tx_l1_ack, 1);
    go <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(tx_l1_ack, 0);
    for (int i = 0; i < 3; i++) begin
      u = i == 1 ? 2 + rnd() % 6 : i + 1;
      apb(1, 12'h008, {15'h0000, i == 2, u[15:0]});
      rx_lanes_active <= i == 2;
      tlp_pending <= i != 1;
      acknak_pending <= i == 1;
      go <= 1'b1;
      ans(20);
      chk(tx_aspm_nak, 1);
      @(posedge mclk);
      {tlp_pending, acknak_pending} <= 2'b00;
      if (i == 2) begin
        ans(40);
        chk(n, 40);
        rx_lanes_active <= 1'b0;
      end
      ans(300);
      chk(tx_l1_ack, 1);
      chk(n >= u * 5 && n <= u * 5 + 8, 1);
      go <= 1'b0;
      repeat (8) @(posedge mclk);
    end
    for (int s = 0; s < 8; s++) begin
      lt_cmd <= s[3:0];
      repeat (3) @(posedge mclk);
      chk(port_link_up_n, !(s >= 3 && s <= 6));
    end
    for (int i = 0; i < 4; i++) begin
      v = i < 2 ? i == 0 : rnd() % 2;
      {tlp_tx, tlp_rx, tlp_is_vendor_msg} <= {i[0], !i[0], v[0]};
      @(posedge mclk);
      {tlp_tx, tlp_rx, tlp_is_vendor_msg} <= 3'h0;
      repeat (45) @(posedge mclk);
      chk(port_activity_n, v);
      repeat (30) @(posedge mclk);
      chk(port_activity_n, 1);
    end
    sel = rnd() % 2;
    apb(1, 12'h004, sel << 6);
    lt_cmd <= 4'h6;
    for (int i = 0; i < 8; i++) begin
      {port_is_downstream, at_gen2, partner_deemph_req} <= i[2:0];
      repeat (4) @(posedge mclk);
      chk(deemph_6db, i[1] & (i[2] ? sel : i[0]));
      if (i[2:1] == 2'b01) chk(tx_deemph_adv, sel);
    end
    lt_cmd <= 4'h3;
    repeat (2) @(posedge mclk);
    {port_is_downstream, partner_deemph_req} <= {1'b0, !sel[0]};
    repeat (4) @(posedge mclk);
    chk(deemph_6db, sel);
    {crosslink_formed, partner_is_upstream, port_is_downstream, at_gen2} <= 4'hc;
    for (int i = 0; i < 4; i++) begin
      train_lanes_downstream <= i[1];
      apb(1, 12'h00c, i);
      apb(0, 12'h014, 0);
      chk(rd[0], !i[0] && i[1]);
      chk(speed_change_req, i[1]);
      chk(crosslink_enable, !i[0]);
    end
    complete_run();
  end
endmodule
bind pplps_port_link pplps_chk_sva #(.ACT_PERIOD_CYC(ACT_PERIOD_CYC)) pplps_chk_sva_inst (
  .mclk, .rstn, .ltssm_state, .rx_l1_request, .port_is_downstream, .tlp_pending, .acknak_pending,
  .tlp_tx, .tlp_rx, .tlp_is_vendor_msg, .at_gen2, .crosslink_formed, .partner_is_upstream, .tx_l1_ack,
  .tx_aspm_nak, .deemph_6db, .speed_change_req, .crosslink_enable, .port_link_up_n, .port_activity_n);
